// ===== rtl/csa_pkg.sv
// constants and types for the cpu-interface sgi alias and group 0 priority split logic
// Contract
// - secure alias write raises non-secure group 1 sgi; non-secure raises secure if permitted
// - with security enabled, non-secure alias sgi skips targets whose access control forbids
// - monitor mode accesses count as secure regardless of the non-secure state bit
// - el1 alias sgi write is undefined when el1 sysreg interface is disabled
// - non-secure el1 alias write traps to el2 on fiq, irq, t12 or sgi trap bits
// - el3 32-bit with fiq and irq routing: el2 and non-monitor el3 alias writes undefined
// - el3 64-bit with fiq and irq routing: secure el1, el2, unrouted ns el1 trap to el3
// - split register is 32 bits, [31:3] read zero, split point in [2:0]
// - split point n gives group priority [7:n+1]; seven means no preemption
// - one split register shared by both security states, not banked
// - non-secure el1 accesses go to the virtual register when hyp fiq routing set
// - minimum split point follows the implemented priority bit count
// - writes below minimum store the minimum; reset loads the minimum
// - split register access undefined from an el whose sysreg interface is disabled
// - non-secure el1 split access traps to el2 on t12 or trap-all-group0
// - el3 32-bit with fiq routing: el2, non-monitor el3, unrouted ns el1 undefined
// - el3 64-bit with fiq routing: secure el1, el2, unrouted ns el1 trap to el3
package csa_pkg;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SPLIT_REG_WIDTH    = 32;
  localparam int unsigned SPLIT_FIELD_LSB    = 0;
  localparam int unsigned SPLIT_FIELD_WIDTH  = 3;
  localparam int unsigned PRIO_WIDTH         = 8;
  localparam int unsigned PRIO_BITS_DEFAULT  = 5;
  localparam int unsigned PRIO_BITS_MAX      = 8;
  localparam int unsigned TARGET_COUNT       = 16;
  localparam logic [2:0]  SPLIT_NO_PREEMPT   = 3'h7;

  // access outcome toward the core
  typedef enum logic [3:0] {
    CSA_RES_OK    = 4'h1,
    CSA_RES_UNDEF = 4'h2,
    CSA_RES_EL2   = 4'h4,
    CSA_RES_EL3   = 4'h8
  } csa_result_type;

  typedef enum logic [1:0] {
    CSA_EL0 = 2'h0,
    CSA_EL1 = 2'h1,
    CSA_EL2 = 2'h2,
    CSA_EL3 = 2'h3
  } csa_el_type;

  // minimum split point for a given number of priority bits
  function automatic logic [2:0] csa_min_split(input logic [3:0] prio_bits);
    logic [3:0] m;
    m = 4'h7 - prio_bits;
    if (prio_bits > 4'h7) begin
      m = 4'h0;
    end
    return m[2:0];
  endfunction : csa_min_split
endpackage : csa_pkg

// ===== rtl/csa_split_mask.sv
// group priority mask derived from a split point value
module csa_split_mask
  import csa_pkg::*;
(
  input  wire logic [2:0] split_in,
  input  wire logic [7:0] priority_in,
  output logic      [7:0] group_mask_out,
  output logic      [7:0] group_prio_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [8:0] ones_below = (9'h002 << split_in) - 9'h001;

  // split seven leaves no group bits, so nothing preempts
  assign group_mask_out = (split_in == SPLIT_NO_PREEMPT) ? 8'h00 : ~ones_below[7:0];
  assign group_prio_out = priority_in & group_mask_out;
endmodule : csa_split_mask

// ===== rtl/csa_sysreg.sv
// sgi alias write control and group 0 priority split register
module csa_sysreg
  import csa_pkg::*;
#(
  parameter int unsigned PRIO_BITS = PRIO_BITS_DEFAULT,
  parameter bit          EL2_IMPL  = 1'b1,
  parameter bit          EL3_IMPL  = 1'b1
) (
  input  wire logic                    mclk_in,
  input  wire logic                    reset_in,
  // access request from the core
  input  wire logic                    acc_valid_in,
  input  wire logic                    acc_write_in,
  input  wire logic                    acc_sel_sgi_in,
  input  wire logic                    acc_sel_split_in,
  input  wire logic [1:0]              acc_el_in,
  input  wire logic                    acc_monitor_in,
  input  wire logic [31:0]             acc_wdata_in,
  input  wire logic [TARGET_COUNT-1:0] acc_targets_in,
  // control bits
  input  wire logic                    nonsecure_state_bit_in,
  input  wire logic                    el3_is_64_in,
  input  wire logic                    secure_fiq_routing_in,
  input  wire logic                    secure_irq_routing_in,
  input  wire logic                    hyp_fiq_routing_in,
  input  wire logic                    hyp_irq_routing_in,
  input  wire logic                    hyp_sysreg_trap_12_in,
  input  wire logic                    hyp_sgi_trap_in,
  input  wire logic                    hyp_trap_all_group0_in,
  input  wire logic                    trap_general_exceptions_in,
  input  wire logic [2:0]              sysreg_interface_enable_in,
  input  wire logic                    distributor_security_disable_in,
  input  wire logic [TARGET_COUNT-1:0] redistributor_nonsecure_access_ctl_in,
  input  wire logic [7:0]              priority_in,
  // answer
  output logic                         acc_done_out,
  output logic [3:0]                   acc_result_out,
  output logic [31:0]                  acc_rdata_out,
  output logic                         virt_access_out,
  output logic                         sgi_valid_out,
  output logic                         sgi_secure_out,
  output logic [TARGET_COUNT-1:0]      sgi_targets_out,
  output logic [2:0]                   priority_bits_count_out,
  output logic [31:0]                  group0_priority_split_out,
  output logic [7:0]                   group_prio_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] PRIO_BITS_4 = 4'(PRIO_BITS);
  localparam logic [2:0] SPLIT_MIN   = csa_min_split(PRIO_BITS_4);

  logic [2:0]              split_reg;
  logic [2:0]              split_next;
  logic                    done_reg;
  logic [3:0]              result_reg;
  logic [31:0]             rdata_reg;
  logic                    virt_reg;
  logic                    sgi_valid_reg;
  logic                    sgi_secure_reg;
  logic [TARGET_COUNT-1:0] sgi_targets_reg;

  // monitor mode is always secure
  wire is_secure  = acc_monitor_in | ~nonsecure_state_bit_in | ~EL3_IMPL;
  wire at_el1     = (acc_el_in == CSA_EL1);
  wire at_el2     = (acc_el_in == CSA_EL2);
  wire at_el3     = (acc_el_in == CSA_EL3);
  wire at_el0     = (acc_el_in == CSA_EL0);
  wire ns_el1     = at_el1 & ~is_secure & ~trap_general_exceptions_in;
  wire s_el1      = at_el1 & is_secure;
  wire el3_non_mon = at_el3 & ~acc_monitor_in;
  wire el3_32     = EL3_IMPL & ~el3_is_64_in;
  wire el3_64     = EL3_IMPL & el3_is_64_in;
  wire sre_off    = (at_el1 & ~sysreg_interface_enable_in[0]) |
                    (at_el2 & ~sysreg_interface_enable_in[1]) |
                    (at_el3 & ~sysreg_interface_enable_in[2]);
  wire el1_tge    = at_el1 & ~is_secure & trap_general_exceptions_in;

  // sgi alias write: write only, no el0 access
  wire sgi_req    = acc_valid_in & acc_sel_sgi_in;
  wire both_route = secure_fiq_routing_in & secure_irq_routing_in;
  wire sgi_undef  = at_el0 | ~acc_write_in | el1_tge |
                    (at_el1 & ~sysreg_interface_enable_in[0]) |
                    (el3_32 & both_route & (at_el2 | el3_non_mon));
  wire sgi_el2    = EL2_IMPL & ns_el1 & (hyp_fiq_routing_in | hyp_irq_routing_in |
                    hyp_sysreg_trap_12_in | hyp_sgi_trap_in);
  wire sgi_el3    = el3_64 & both_route & (s_el1 | at_el2 |
                    (ns_el1 & ~hyp_irq_routing_in & ~hyp_fiq_routing_in));
  wire sgi_ok     = sgi_req & ~sgi_undef & ~sgi_el2 & ~sgi_el3;
  // with distributor security enabled, non-secure sources raise secure sgis only where allowed per target
  wire [TARGET_COUNT-1:0] sgi_allowed = is_secure ? acc_targets_in :
       (distributor_security_disable_in ? acc_targets_in :
        (acc_targets_in & redistributor_nonsecure_access_ctl_in));

  // group 0 split register access
  wire split_req   = acc_valid_in & acc_sel_split_in;
  wire split_undef = at_el0 | el1_tge | sre_off |
                     (el3_32 & secure_fiq_routing_in & (at_el2 | el3_non_mon |
                      (ns_el1 & ~hyp_fiq_routing_in)));
  wire split_virt  = ns_el1 & hyp_fiq_routing_in;
  wire split_el2   = EL2_IMPL & ns_el1 & (hyp_sysreg_trap_12_in | hyp_trap_all_group0_in);
  wire split_el3   = el3_64 & secure_fiq_routing_in & (s_el1 | at_el2 |
                     (ns_el1 & ~hyp_fiq_routing_in));
  wire split_ok    = split_req & ~split_undef & ~split_el2 & ~split_el3;
  wire split_wr    = split_ok & acc_write_in & ~split_virt;
  wire [2:0] wfield = acc_wdata_in[SPLIT_FIELD_LSB +: SPLIT_FIELD_WIDTH];

  // below-minimum writes store the minimum; one copy serves both states
  assign split_next = split_wr ? ((wfield < SPLIT_MIN) ? SPLIT_MIN : wfield) : split_reg;

  // undefined outranks traps; el2 traps outrank el3 traps for ns el1
  wire [3:0] result_sel = (sgi_req & sgi_undef) | (split_req & split_undef) ? CSA_RES_UNDEF :
                          (sgi_req & sgi_el2) | (split_req & split_el2) ? CSA_RES_EL2 :
                          (sgi_req & sgi_el3) | (split_req & split_el3) ? CSA_RES_EL3 :
                          CSA_RES_OK;
  wire [31:0] rdata_sel = (split_ok & ~acc_write_in & ~split_virt) ?
                          {29'h0000000, split_reg} : 32'h00000000;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      split_reg <= SPLIT_MIN;
    end else begin
      split_reg <= split_next;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      done_reg   <= 1'b0;
      result_reg <= 4'h0;
      rdata_reg  <= 32'h00000000;
      virt_reg   <= 1'b0;
    end else begin
      done_reg   <= acc_valid_in;
      result_reg <= acc_valid_in ? result_sel : 4'h0;
      rdata_reg  <= rdata_sel;
      virt_reg   <= split_ok & split_virt;
    end
  end

  // secure writer targets non-secure group 1 and vice versa
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sgi_valid_reg   <= 1'b0;
      sgi_secure_reg  <= 1'b0;
      sgi_targets_reg <= '0;
    end else begin
      sgi_valid_reg   <= sgi_ok & (|sgi_allowed);
      sgi_secure_reg  <= ~is_secure;
      sgi_targets_reg <= sgi_ok ? sgi_allowed : '0;
    end
  end

  csa_split_mask u_mask (
    .split_in       (split_reg),
    .priority_in    (priority_in),
    .group_mask_out (),
    .group_prio_out (group_prio_out)
  );

  assign acc_done_out              = done_reg;
  assign acc_result_out            = result_reg;
  assign acc_rdata_out             = rdata_reg;
  assign virt_access_out           = virt_reg;
  assign sgi_valid_out             = sgi_valid_reg;
  assign sgi_secure_out            = sgi_secure_reg;
  assign sgi_targets_out           = sgi_targets_reg;
  assign priority_bits_count_out   = 3'(PRIO_BITS_4 - 4'h1);
  assign group0_priority_split_out = {29'h0000000, split_reg};
endmodule : csa_sysreg

// ===== verification/csa_core_model.sv
// core-side model: issues one system register access and returns its answer
module csa_core_model
(
  input  wire logic       mclk_in,
  input  wire logic       acc_done_out,
  input  wire logic [3:0] acc_result_out,
  output logic acc_valid_in, acc_write_in, acc_sel_sgi_in, acc_sel_split_in, acc_monitor_in,
  output logic [1:0]      acc_el_in,
  output logic [31:0]     acc_wdata_in,
  output logic [15:0]     acc_targets_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {acc_valid_in, acc_write_in, acc_sel_sgi_in, acc_sel_split_in, acc_monitor_in, acc_el_in} = 7'h0;
    acc_wdata_in = 32'h0;
    acc_targets_in = 16'h0;
  end
  // released data is inverted so a stale value can never pass for live data
  task automatic issue(input logic [5:0] req, input logic [31:0] wd, output logic [3:0] res);
    @(posedge mclk_in);
    #1;
    {acc_write_in, acc_sel_sgi_in, acc_sel_split_in, acc_monitor_in, acc_el_in} = req;
    acc_wdata_in = wd;
    acc_targets_in = wd[15:0];
    acc_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    acc_valid_in = 1'b0;
    acc_wdata_in = ~wd;
    acc_targets_in = ~wd[15:0];
    res = acc_done_out ? acc_result_out : 4'hF;
  endtask : issue
endmodule : csa_core_model

// ===== verification/csa_sysreg_props.sv
// assertions on the sgi alias and group 0 split register ports
module csa_sysreg_props
  import csa_pkg::*;
#(parameter int unsigned PRIO_BITS = PRIO_BITS_DEFAULT)
(
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        acc_valid_in,
  input wire logic        acc_write_in,
  input wire logic        acc_sel_sgi_in,
  input wire logic [1:0]  acc_el_in,
  input wire logic [2:0]  sysreg_interface_enable_in,
  input wire logic        acc_done_out,
  input wire logic [3:0]  acc_result_out,
  input wire logic        sgi_valid_out,
  input wire logic [31:0] group0_priority_split_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] MIN_SPLIT = 3'(7 - PRIO_BITS);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence req_s; acc_valid_in; endsequence
  sequence refused_s; acc_done_out && acc_result_out != 4'h1; endsequence
  answer_once_a: assert property (req_s |=> acc_done_out && $onehot(acc_result_out))
    else $error("request without a single answer");
  el0_undef_a: assert property (req_s ##0 acc_el_in == 2'h0 |=> acc_result_out == 4'h2)
    else $error("el0 access not undefined");
  sgi_read_a: assert property (req_s ##0 (acc_sel_sgi_in && !acc_write_in) |=> acc_result_out == 4'h2)
    else $error("alias read not undefined");
  el1_off_a: assert property (req_s ##0 (acc_el_in == 2'h1 && !sysreg_interface_enable_in[0])
    |=> acc_result_out == 4'h2) else $error("el1 access with interface off not undefined");
  reserved_zero_a: assert property (group0_priority_split_out[31:3] == 29'h0)
    else $error("split register reserved bits set");
  clamp_min_a: assert property (group0_priority_split_out[2:0] >= MIN_SPLIT)
    else $error("split field below minimum");
  refused_hold_a: assert property (req_s ##1 refused_s |-> $stable(group0_priority_split_out))
    else $error("refused access changed split register");
  sgi_ok_a: assert property (sgi_valid_out |-> acc_done_out && acc_result_out == 4'h1)
    else $error("sgi raised without accepted write");
endmodule : csa_sysreg_props

bind csa_sysreg csa_sysreg_props #(.PRIO_BITS(PRIO_BITS)) props_i (.*);

// ===== verification/csa_sysreg_tb.sv
// self-checking bench for the sgi alias and group 0 split register
module csa_sysreg_tb
  import csa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PB = 5;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic acc_valid_in, acc_write_in, acc_sel_sgi_in, acc_sel_split_in, acc_monitor_in, acc_done_out;
  logic nonsecure_state_bit_in, el3_is_64_in, secure_fiq_routing_in, secure_irq_routing_in;
  logic hyp_fiq_routing_in, hyp_irq_routing_in, hyp_sysreg_trap_12_in, hyp_sgi_trap_in;
  logic hyp_trap_all_group0_in, trap_general_exceptions_in, distributor_security_disable_in;
  logic virt_access_out, sgi_valid_out, sgi_secure_out;
  logic [1:0] acc_el_in;
  logic [2:0] sysreg_interface_enable_in, priority_bits_count_out;
  logic [3:0] acc_result_out;
  logic [7:0] priority_in, group_prio_out, gm;
  logic [13:0] ctl = 14'h100E;
  logic [15:0] acc_targets_in, redistributor_nonsecure_access_ctl_in, sgi_targets_out;
  logic [31:0] acc_wdata_in, acc_rdata_out, group0_priority_split_out;
  int fail_count = 0;
  int checks = 0;
  assign {nonsecure_state_bit_in, el3_is_64_in, secure_fiq_routing_in, secure_irq_routing_in,
          hyp_fiq_routing_in, hyp_irq_routing_in, hyp_sysreg_trap_12_in, hyp_sgi_trap_in, hyp_trap_all_group0_in,
          trap_general_exceptions_in, sysreg_interface_enable_in, distributor_security_disable_in} = ctl;
  always #2 mclk_in = ~mclk_in;
  csa_sysreg #(.PRIO_BITS(PB)) uut (.*);
  csa_core_model core (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one access under control word c, then its result code
  task automatic t(input logic [13:0] c, input logic [5:0] r, input logic [31:0] wd, input logic [3:0] er);
    logic [3:0] res;
    ctl = c;
    core.issue(r, wd, res);
    chk("result", {28'h0, er}, {28'h0, res});
  endtask : t
  task automatic results;
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    priority_in = 8'hFF;
    redistributor_nonsecure_access_ctl_in = 16'h000F;
    repeat (16) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    chk("split reset", 32'(7 - PB), group0_priority_split_out);
    chk("prio bits", 32'(PB - 1), {29'h0, priority_bits_count_out});
    for (int n = 0; n < 8; n++) begin
      t(14'h100E, 6'h2F, 32'hFFFF_FFF8 | n, 4'h1);
      gm = 8'hFF << (((n < 7 - PB) ? 7 - PB : n) + 1);
      chk("split", (n < 7 - PB) ? 7 - PB : n, group0_priority_split_out);
      chk("group prio", {24'h0, gm}, {24'h0, group_prio_out});
    end
    t(14'h300E, 6'h29, 32'h3, 4'h1);
    t(14'h100E, 6'h0F, 32'h0, 4'h1);
    chk("read", 32'h3, acc_rdata_out);
    t(14'h100E, 6'h08, 32'h0, 4'h2);
    t(14'h100E, 6'h11, 32'h0, 4'h2);
    t(14'h100C, 6'h31, 32'h0, 4'h2);
    t(14'h100A, 6'h2A, 32'h0, 4'h2);
    t(14'h308E, 6'h29, 32'h0, 4'h4);
    t(14'h302E, 6'h09, 32'h0, 4'h4);
    t(14'h320E, 6'h31, 32'h0, 4'h4);
    t(14'h304E, 6'h31, 32'h0, 4'h4);
    t(14'h2C0E, 6'h32, 32'h0, 4'h2);
    t(14'h0C0E, 6'h33, 32'h0, 4'h2);
    t(14'h2C0E, 6'h37, 32'h1, 4'h1);
    chk("sgi", 32'h20001, {sgi_valid_out, sgi_secure_out, sgi_targets_out});
    t(14'h1C0E, 6'h31, 32'h0, 4'h8);
    t(14'h3C0E, 6'h32, 32'h0, 4'h8);
    t(14'h3C0E, 6'h31, 32'h0, 4'h8);
    t(14'h180E, 6'h09, 32'h0, 4'h8);
    t(14'h380E, 6'h2A, 32'h0, 4'h8);
    t(14'h380E, 6'h29, 32'h0, 4'h8);
    t(14'h280E, 6'h2A, 32'h0, 4'h2);
    t(14'h080E, 6'h0B, 32'h0, 4'h2);
    t(14'h280E, 6'h09, 32'h0, 4'h2);
    t(14'h320E, 6'h29, 32'h6, 4'h1);
    chk("virtual", 32'h1, {31'h0, virt_access_out});
    chk("split kept", 32'h3, group0_priority_split_out);
    t(14'h100E, 6'h31, 32'h00FF, 4'h1);
    chk("sgi", 32'h200FF, {sgi_valid_out, sgi_secure_out, sgi_targets_out});
    t(14'h300E, 6'h31, 32'h00FF, 4'h1);
    chk("sgi", 32'h3000F, {sgi_valid_out, sgi_secure_out, sgi_targets_out});
    results();
  end
endmodule : csa_sysreg_tb
